// File: shared/kbh_pkg.sv
package kbh_pkg;
  // host i/o addresses (relocatable through base inputs)
  localparam logic [7:0] KBH_DATA_OFS      = 8'h60;
  localparam logic [7:0] KBH_CMD_OFS       = 8'h64;
  // status bit positions
  localparam int KBH_ST_OBF   = 0;
  localparam int KBH_ST_IBF   = 1;
  localparam int KBH_ST_SYS   = 2;
  localparam int KBH_ST_CD    = 3;
  localparam int KBH_ST_INH   = 4;
  localparam int KBH_ST_AUX   = 5;
  localparam int KBH_ST_TMO   = 6;
  localparam int KBH_ST_PAR   = 7;
  // command byte bit positions; command byte and output port reset values
  localparam int KBH_CB_KBIE  = 0;
  localparam int KBH_CB_AUXIE = 1;
  localparam int KBH_CB_SYS   = 2;
  localparam int KBH_CB_KBDIS = 4;
  localparam int KBH_CB_AUXDIS= 5;
  localparam int KBH_CB_XLAT  = 6;
  localparam logic [7:0] KBH_CB_RST = 8'h00;
  localparam logic [7:0] KBH_OUTP_RST = 8'h03;
  // commands
  localparam logic [7:0] KBH_C_RDCB  = 8'h20;
  localparam logic [7:0] KBH_C_WRCB  = 8'h60;
  localparam logic [7:0] KBH_C_PWTST = 8'ha4;
  localparam logic [7:0] KBH_C_PWLD  = 8'ha5;
  localparam logic [7:0] KBH_C_PWEN  = 8'ha6;
  localparam logic [7:0] KBH_C_AUXD  = 8'ha7;
  localparam logic [7:0] KBH_C_AUXE  = 8'ha8;
  localparam logic [7:0] KBH_C_AUXT  = 8'ha9;
  localparam logic [7:0] KBH_C_SELF  = 8'haa;
  localparam logic [7:0] KBH_C_KBT   = 8'hab;
  localparam logic [7:0] KBH_C_RDIN  = 8'hc0;
  localparam logic [7:0] KBH_C_INLO  = 8'hc1;
  localparam logic [7:0] KBH_C_INHI  = 8'hc2;
  localparam logic [7:0] KBH_C_RDOUT = 8'hd0;
  localparam logic [7:0] KBH_C_WROUT = 8'hd1;
  localparam logic [7:0] KBH_C_ECKB  = 8'hd2;
  localparam logic [7:0] KBH_C_ECAUX = 8'hd3;
  localparam logic [7:0] KBH_C_TXAUX = 8'hd4;
  // replies
  localparam logic [7:0] KBH_R_PWYES = 8'hfa;
  localparam logic [7:0] KBH_R_PWNO  = 8'hf1;
  localparam logic [7:0] KBH_R_SELF  = 8'h55;
  localparam logic [7:0] KBH_R_T_OK  = 8'h00;
  localparam logic [7:0] KBH_R_T_CLO = 8'h01;
  localparam logic [7:0] KBH_R_T_CHI = 8'h02;
  localparam logic [7:0] KBH_R_T_DLO = 8'h03;
  localparam logic [7:0] KBH_R_T_DHI = 8'h04;
  // reset pulse timing and password depth
  localparam int KBH_CLK_MHZ     = 10;
  localparam int KBH_RST_US      = 6;
  localparam int KBH_RST_CYC     = KBH_RST_US * KBH_CLK_MHZ;
  localparam int KBH_PW_DEPTH    = 8;
  typedef enum logic [2:0] {
    KBH_S_IDLE  = 3'b000,
    KBH_S_PARAM = 3'b001,
    KBH_S_PWLD  = 3'b011
  } kbh_state_t;
  typedef enum logic [2:0] {
    KBH_P_NONE, KBH_P_WRCB, KBH_P_WROUT, KBH_P_ECKB, KBH_P_ECAUX, KBH_P_TXAUX
  } kbh_param_t;
endpackage

// File: core/kbh_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module kbh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign push = in_valid && in_ready && clk_en;
  assign pop  = out_valid && out_ready && clk_en;
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // kbh_fifo
`default_nettype wire

// File: core/kbh_host_port.sv
// Notes on behaviour
// (R1) write-only input byte buffer reachable at data and command addresses, both relocatable
// (R2) data-address write marks data, command-address write marks command; shown in status bit 3
// (R3) data bytes go to keyboard unless a parameter awaited; host writes only when ibf clear
// (R4) status register readable at command address anytime without side effects
// (R5) status bit 0 is output full, bit 1 is input full
// (R6) status bit 2 mirrors system flag, zero after reset
// (R7) bit 4 shows keyboard inhibit, bit 5 marks auxiliary origin of output byte
// (R8) bit 6 flags time-out, bit 7 flags even parity on received byte
// (R9) 20h returns command byte, 60h loads next data as command byte
// (R10) command byte fields: translate, aux disable, kb disable, sysflag, interrupt enables
// (R11) a4h answers fah when password loaded, f1h otherwise
// (R12) a5h takes data bytes as password until zero byte
// (R13) a6h enables keystroke comparison with password when one is loaded, otherwise it clears the enable
// (R14) a7h disables auxiliary interface, a8h enables it; a8h leaves it disabled while command byte bit 5 is set
// (R15) a9h and abh return one interface test code 00 to 04
// (R16) aah self-test answers 55h
// (R17) c0h returns input port, d0h returns output port
// (R18) c1h/c2h keep copying low/high input port nibble into status upper bits
// (R19) d1h sets address-line-20 gate from bit 1 of next data byte only
// (R20) d2h/d3h echo next data byte as keyboard/auxiliary byte
// (R21) d4h sends next data byte to auxiliary device
// (R22) even fxh command pulses system reset line low for 6 us
// (R23) output buffer read at data address; host reads only while obf set
// (R24) host read clears obf; consuming host byte clears ibf
`timescale 1ns/1ps
`default_nettype none
module kbh_host_port
  import kbh_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic [7:0] data_port_base,
  input  wire logic [7:0] command_port_base,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [7:0] io_addr,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  input  wire logic [7:0] input_port,
  input  wire logic       kbd_inhibit_n,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_aux,
  input  wire logic       rx_parity_err,
  input  wire logic       rx_timeout,
  output logic            rx_ready,
  input  wire logic [7:0] kbd_test_code,
  input  wire logic [7:0] aux_test_code,
  output logic            tx_valid,
  input  wire logic       tx_ready,
  output logic      [7:0] tx_data,
  output logic            tx_aux,
  output logic      [7:0] output_port,
  output logic            address_line_20_gate,
  output logic            system_reset_line,
  output logic      [7:0] command_byte,
  output logic            aux_if_disabled,
  output logic            password_enabled
);
  // pin-side inputs synchronised; first stage read only by second
  logic [7:0] inp_s1_r, inp_r;
  logic       inh_s1_r, inh_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      inp_s1_r <= 8'h00;
      inp_r    <= 8'h00;
      inh_s1_r <= 1'b1;
      inh_r    <= 1'b1;
    end else if (clk_en) begin
      inp_s1_r <= input_port;
      inp_r    <= inp_s1_r;
      inh_s1_r <= kbd_inhibit_n;
      inh_r    <= inh_s1_r;
    end
  end

  logic [7:0] ib_r, ob_r, cb_r, outp_r;
  logic       ibf_r, obf_r, cd_r, ob_aux_r, tmo_r, par_r;
  logic [1:0] nib_mode_r;
  logic       pw_loaded_r, pw_en_r, auxdis_r;
  logic [$clog2(KBH_PW_DEPTH)-1:0] pw_cnt_r;
  logic [7:0] pw_mem_r [KBH_PW_DEPTH];
  kbh_state_t st_r;
  kbh_param_t pend_r;
  logic [7:0] rst_cnt_r;

  logic wr_data, wr_cmd, rd_data, rd_stat, consume;
  logic [7:0] status;
  assign wr_data = io_wr && (io_addr == data_port_base);    // (R1)
  assign wr_cmd  = io_wr && (io_addr == command_port_base); // (R1)
  assign rd_data = io_rd && (io_addr == data_port_base);    // (R23)
  assign rd_stat = io_rd && (io_addr == command_port_base); // (R4)

  // fifo toward the serial side; consume of a byte bound for it stalls while it is full
  logic       fq_valid, fq_ready;
  logic [8:0] fq_data;
  logic [8:0] fo_data;
  kbh_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_txq (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .in_valid  (fq_valid),
    .in_ready  (fq_ready),
    .in_data   (fq_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (fo_data)
  );
  assign tx_data = fo_data[7:0];
  assign tx_aux  = fo_data[8];

  logic is_param, to_kbd, to_aux, ob_load;
  logic [7:0] ob_val;
  logic       ob_val_aux;
  assign is_param = (st_r != KBH_S_IDLE);
  assign to_kbd   = ibf_r && !cd_r && !is_param;                              // (R3)
  assign to_aux   = ibf_r && !cd_r && (st_r == KBH_S_PARAM) && (pend_r == KBH_P_TXAUX); // (R21)
  assign fq_valid = to_kbd || to_aux;
  assign fq_data  = {to_aux, ib_r};
  // byte consumed once the serial queue accepts it or the command logic takes it
  assign consume  = ibf_r && (fq_valid ? fq_ready : 1'b1);                   // (R24)

  // receive path only accepted while the host buffer is free
  assign rx_ready = !obf_r && !ob_load;

  always_comb begin
    ob_load    = 1'b0;
    ob_val     = 8'h00;
    ob_val_aux = 1'b0;
    if (consume && cd_r) begin
      ob_load = 1'b1;
      unique case (ib_r)
        KBH_C_RDCB:  ob_val = cb_r;                                    // (R9)
        KBH_C_PWTST: ob_val = pw_loaded_r ? KBH_R_PWYES : KBH_R_PWNO;  // (R11)
        KBH_C_AUXT:  ob_val = aux_test_code;                           // (R15)
        KBH_C_KBT:   ob_val = kbd_test_code;                           // (R15)
        KBH_C_SELF:  ob_val = KBH_R_SELF;                              // (R16)
        KBH_C_RDIN:  ob_val = inp_r;                                   // (R17)
        KBH_C_RDOUT: ob_val = outp_r;                                  // (R17)
        default:     ob_load = 1'b0;
      endcase
    end else if (consume && !cd_r && st_r == KBH_S_PARAM
                 && (pend_r == KBH_P_ECKB || pend_r == KBH_P_ECAUX)) begin
      ob_load    = 1'b1;                                               // (R20)
      ob_val     = ib_r;
      ob_val_aux = (pend_r == KBH_P_ECAUX);
    end
  end

  // input buffer and its flags
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ib_r  <= 8'h00;
      ibf_r <= 1'b0;
      cd_r  <= 1'b0;
    end else if (clk_en) begin
      if (wr_data || wr_cmd) begin
        ib_r  <= io_wdata;
        ibf_r <= 1'b1;     // set wins over consume
        cd_r  <= wr_cmd;   // (R2)
      end else if (consume) begin
        ibf_r <= 1'b0;     // (R24)
      end
    end
  end

  // output buffer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ob_r     <= 8'h00;
      obf_r    <= 1'b0;
      ob_aux_r <= 1'b0;
      tmo_r    <= 1'b0;
      par_r    <= 1'b0;
    end else if (clk_en) begin
      if (ob_load) begin
        ob_r     <= ob_val;
        obf_r    <= 1'b1;
        ob_aux_r <= ob_val_aux;
        par_r    <= 1'b0;
        tmo_r    <= 1'b0;
      end else if (rx_valid && rx_ready) begin
        ob_r     <= rx_data;
        obf_r    <= 1'b1;
        ob_aux_r <= rx_aux;          // (R7)
        par_r    <= rx_parity_err;   // (R8)
        tmo_r    <= rx_timeout;      // (R8)
      end else if (rd_data) begin
        obf_r    <= 1'b0;            // (R24)
      end
    end
  end

  // command sequencing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r   <= KBH_S_IDLE;
      pend_r <= KBH_P_NONE;
    end else if (clk_en && consume) begin
      if (cd_r) begin
        st_r   <= KBH_S_IDLE;
        pend_r <= KBH_P_NONE;
        unique case (ib_r)
          KBH_C_WRCB:  begin st_r <= KBH_S_PARAM; pend_r <= KBH_P_WRCB;  end // (R9)
          KBH_C_WROUT: begin st_r <= KBH_S_PARAM; pend_r <= KBH_P_WROUT; end // (R19)
          KBH_C_ECKB:  begin st_r <= KBH_S_PARAM; pend_r <= KBH_P_ECKB;  end // (R20)
          KBH_C_ECAUX: begin st_r <= KBH_S_PARAM; pend_r <= KBH_P_ECAUX; end // (R20)
          KBH_C_TXAUX: begin st_r <= KBH_S_PARAM; pend_r <= KBH_P_TXAUX; end // (R21)
          KBH_C_PWLD:  st_r <= KBH_S_PWLD;                                   // (R12)
          default:     st_r <= KBH_S_IDLE;
        endcase
      end else if (st_r == KBH_S_PARAM) begin
        st_r   <= KBH_S_IDLE;
        pend_r <= KBH_P_NONE;
      end else if (st_r == KBH_S_PWLD && ib_r == 8'h00) begin
        st_r <= KBH_S_IDLE;                                                  // (R12)
      end
    end
  end

  // command byte, port, password and interface state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cb_r        <= KBH_CB_RST;   // (R6)
      outp_r      <= KBH_OUTP_RST;
      auxdis_r    <= 1'b0;
      pw_en_r     <= 1'b0;
      pw_loaded_r <= 1'b0;
      pw_cnt_r    <= '0;
      nib_mode_r  <= 2'b00;
    end else if (clk_en && consume) begin
      if (cd_r) begin
        unique case (ib_r)
          KBH_C_PWLD: begin pw_cnt_r <= '0; pw_loaded_r <= 1'b0; end
          KBH_C_PWEN: pw_en_r <= pw_loaded_r;     // (R13)
          KBH_C_AUXD: auxdis_r <= 1'b1;           // (R14)
          KBH_C_AUXE: auxdis_r <= 1'b0;           // (R14)
          KBH_C_INLO: nib_mode_r <= 2'b01;        // (R18)
          KBH_C_INHI: nib_mode_r <= 2'b10;        // (R18)
          default: ;
        endcase
      end else if (st_r == KBH_S_PARAM && pend_r == KBH_P_WRCB) begin
        cb_r <= ib_r;                             // (R9) (R10)
      end else if (st_r == KBH_S_PARAM && pend_r == KBH_P_WROUT) begin
        outp_r[1] <= ib_r[1];                     // (R19)
      end else if (st_r == KBH_S_PWLD) begin
        if (ib_r == 8'h00) begin
          pw_loaded_r <= (pw_cnt_r != '0);        // (R12)
        end else if (pw_cnt_r != '1) begin
          pw_cnt_r <= pw_cnt_r + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (clk_en && consume && !cd_r && st_r == KBH_S_PWLD && ib_r != 8'h00) begin
      pw_mem_r[pw_cnt_r] <= ib_r;
    end
  end

  // reset pulse on even fxh; long enough counter for 6 us
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt_r <= 8'h00;
    end else if (clk_en) begin
      if (consume && cd_r && ib_r[7:4] == 4'hf && !ib_r[0]) begin
        rst_cnt_r <= 8'(KBH_RST_CYC);            // (R22)
      end else if (rst_cnt_r != 8'h00) begin
        rst_cnt_r <= rst_cnt_r - 8'h01;
      end
    end
  end

  always_comb begin
    status = 8'h00;
    status[KBH_ST_OBF] = obf_r;                  // (R5)
    status[KBH_ST_IBF] = ibf_r;                  // (R5)
    status[KBH_ST_SYS] = cb_r[KBH_CB_SYS];       // (R6)
    status[KBH_ST_CD]  = cd_r;                   // (R2)
    status[KBH_ST_INH] = inh_r;                  // (R7)
    status[KBH_ST_AUX] = ob_aux_r;               // (R7)
    status[KBH_ST_TMO] = tmo_r;                  // (R8)
    status[KBH_ST_PAR] = par_r;                  // (R8)
    // nibble read straight from the synced port, so no stale copy after c1h/c2h
    if (nib_mode_r == 2'b01) status[7:4] = inp_r[3:0]; // (R18)
    if (nib_mode_r == 2'b10) status[7:4] = inp_r[7:4]; // (R18)
  end

  // read data registered; status reads touch no state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata <= 8'h00;
    end else if (clk_en) begin
      if (rd_stat) io_rdata <= status;           // (R4)
      else if (rd_data) io_rdata <= ob_r;        // (R23)
    end
  end

  assign output_port          = outp_r;
  assign address_line_20_gate = outp_r[1];      // (R19)
  assign system_reset_line    = (rst_cnt_r == 8'h00); // (R22)
  assign command_byte         = cb_r;
  assign aux_if_disabled      = auxdis_r | cb_r[KBH_CB_AUXDIS];
  assign password_enabled     = pw_en_r;
endmodule // kbh_host_port
`default_nettype wire

// File: testbench/kbh_host_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
module kbh_host_port_properties
  import kbh_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       io_wr,
  input wire logic       io_rd,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic [7:0] command_port_base,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic       tx_aux,
  input wire logic [7:0] output_port,
  input wire logic       address_line_20_gate,
  input wire logic       system_reset_line,
  input wire logic       aux_if_disabled,
  input wire logic       password_enabled
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic       cmd_wr;
  logic [7:0] low_cnt_r;
  logic [5:0] fx_sh_r;
  assign cmd_wr = io_wr && io_addr == command_port_base;
  // cycles the reset line has been sampled low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) low_cnt_r <= 8'h00;
    else if (system_reset_line) low_cnt_r <= 8'h00;
    else low_cnt_r <= low_cnt_r + 8'h01;
  end
  // window wide enough for write, consume and pulse start
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) fx_sh_r <= 6'h00;
    else fx_sh_r <= {fx_sh_r[4:0], cmd_wr && io_wdata[7:4] == 4'hf && !io_wdata[0]};
  end
  sequence seq_cmd(logic [7:0] c);
    cmd_wr && io_wdata == c;
  endsequence
  chk_rdata_holds: assert property (!io_rd |=> $stable(io_rdata))
    else $error("read data changed without a read");
  chk_tx_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_aux))
    else $error("tx byte dropped or changed while stalled");
  chk_gate_bit: assert property ($changed(output_port) |->
    (output_port ^ $past(output_port)) == 8'h02 && address_line_20_gate == output_port[1])
    else $error("gate differs from output port bit 1");
  chk_pulse_length: assert property ($rose(system_reset_line) |-> low_cnt_r == 8'(KBH_RST_CYC))
    else $error("reset pulse length wrong");
  chk_pulse_cause: assert property ($fell(system_reset_line) |-> |fx_sh_r)
    else $error("reset pulse without even fx command");
  chk_aux_off: assert property (seq_cmd(KBH_C_AUXD) |-> ##[1:3] aux_if_disabled)
    else $error("aux interface not disabled");
  chk_aux_on: assert property (seq_cmd(KBH_C_AUXE) |-> ##[1:3] !aux_if_disabled)
    else $error("aux interface not enabled");
  chk_pw_enable: assert property (seq_cmd(KBH_C_PWEN) |-> ##[1:3] password_enabled)
    else $error("password check not enabled");
endmodule // kbh_host_port_properties
`default_nettype wire

// File: testbench/kbh_kbd_model.sv
`timescale 1ns/1ps
`default_nettype none
module kbh_kbd_model (
  input  wire logic       core_clk,
  input  wire logic       stall,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_aux,
  output logic            tx_ready,
  input  wire logic       rx_ready,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            rx_aux,
  output logic            rx_parity_err,
  output logic            rx_timeout
);
  logic [8:0] got_q[$];
  assign tx_ready = !stall;
  initial begin
    rx_valid = 1'b0;
    {rx_data, rx_aux, rx_parity_err, rx_timeout} = 11'h000;
  end
  always @(posedge core_clk) begin
    if (tx_valid && tx_ready) got_q.push_back({tx_aux, tx_data});
  end
  // hold the byte until taken or for at most 200 cycles; afterwards the lines show junk, not the old byte
  task automatic send(input logic [7:0] d, input logic a, input logic pe, input logic to);
    int n;
    n = 0;
    @(posedge core_clk);
    rx_valid <= 1'b1;
    {rx_data, rx_aux, rx_parity_err, rx_timeout} <= {d, a, pe, to};
    @(negedge core_clk);
    while (!rx_ready && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
    rx_valid <= 1'b0;
    {rx_data, rx_aux, rx_parity_err, rx_timeout} <= ~{d, a, pe, to};
  endtask
endmodule // kbh_kbd_model
`default_nettype wire

// File: testbench/keyboard_controller_host_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module keyboard_controller_host_port_test;
  import kbh_pkg::*;
  logic       core_clk, rst_n, io_wr, io_rd, kbd_inhibit_n, stall;
  logic [7:0] io_addr, io_wdata, io_rdata, input_port, kbd_test_code, aux_test_code;
  logic [7:0] rx_data, tx_data, output_port, command_byte;
  logic       rx_valid, rx_aux, rx_parity_err, rx_timeout, rx_ready, tx_valid, tx_ready;
  logic       tx_aux, address_line_20_gate, system_reset_line, aux_if_disabled;
  logic       password_enabled;
  int         errors = 0, check_count = 0, cycles = 0;
  kbh_host_port dut (.core_clk, .rst_n, .clk_en(1'b1), .data_port_base(KBH_DATA_OFS),
    .command_port_base(KBH_CMD_OFS), .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata,
    .input_port, .kbd_inhibit_n, .rx_valid, .rx_data, .rx_aux, .rx_parity_err, .rx_timeout,
    .rx_ready, .kbd_test_code, .aux_test_code, .tx_valid, .tx_ready, .tx_data, .tx_aux,
    .output_port, .address_line_20_gate, .system_reset_line, .command_byte,
    .aux_if_disabled, .password_enabled);
  kbh_kbd_model kbd (.core_clk, .stall, .tx_valid, .tx_data, .tx_aux, .tx_ready, .rx_ready,
    .rx_valid, .rx_data, .rx_aux, .rx_parity_err, .rx_timeout);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // generous ceiling; the full run needs under two thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    io_rd <= 1'b1;
    io_addr <= a;
    @(posedge core_clk);
    io_rd <= 1'b0;
    #1 v = io_rdata;
  endtask
  task automatic poll(input int b, input logic lvl, output logic [7:0] s);
    int n;
    n = 0;
    do begin
      rd(KBH_CMD_OFS, s);
      n++;
    end while (s[b] !== lvl && n < 40);
  endtask
  // host writes once the input buffer is seen empty or after 40 status reads
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] s;
    poll(KBH_ST_IBF, 1'b0, s);
    @(posedge core_clk);
    io_wr <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge core_clk);
    io_wr <= 1'b0;
  endtask
  task automatic ob(input string what, input logic [7:0] exp, output logic [7:0] s);
    logic [7:0] v;
    poll(KBH_ST_OBF, 1'b1, s);
    rd(KBH_DATA_OFS, v);
    check(what, exp, v);
    rd(KBH_CMD_OFS, v);
    check("obf after read", 8'h00, {7'h00, v[KBH_ST_OBF]});
  endtask
  task automatic t_basic();
    logic [7:0] s;
    rd(KBH_CMD_OFS, s);
    check("status after reset", 8'h00, {5'h00, s[2:0]});
    check("output port", KBH_OUTP_RST, output_port);
    check("reset line", 8'h01, {7'h00, system_reset_line});
    wr(KBH_CMD_OFS, KBH_C_WRCB);
    wr(KBH_DATA_OFS, 8'h45);
    poll(KBH_ST_IBF, 1'b0, s);
    check("command byte", 8'h45, command_byte);
    check("sys flag and cd", 8'h01, {6'h00, s[KBH_ST_CD], s[KBH_ST_SYS]});
    wr(KBH_CMD_OFS, KBH_C_RDCB);
    ob("command byte read", 8'h45, s);
    check("cd after command", 8'h01, {7'h00, s[KBH_ST_CD]});
    $display("test basic done");
  endtask
  task automatic t_replies();
    logic [7:0] s;
    for (int i = 0; i < 5; i++) begin
      @(posedge core_clk);
      kbd_test_code <= 8'(i);
      aux_test_code <= 8'(4 - i);
      wr(KBH_CMD_OFS, KBH_C_KBT);
      ob("kbd test", 8'(i), s);
      wr(KBH_CMD_OFS, KBH_C_AUXT);
      ob("aux test", 8'(4 - i), s);
    end
    wr(KBH_CMD_OFS, KBH_C_SELF);
    ob("self test", KBH_R_SELF, s);
    wr(KBH_CMD_OFS, KBH_C_RDIN);
    ob("input port", input_port, s);
    wr(KBH_CMD_OFS, KBH_C_RDOUT);
    ob("output port read", KBH_OUTP_RST, s);
    wr(KBH_CMD_OFS, KBH_C_PWTST);
    ob("no password", KBH_R_PWNO, s);
    $display("test replies done");
  endtask
  task automatic t_modes();
    logic [7:0] s;
    wr(KBH_CMD_OFS, KBH_C_PWLD);
    wr(KBH_DATA_OFS, 8'h11);
    wr(KBH_DATA_OFS, 8'h22);
    wr(KBH_DATA_OFS, 8'h00);
    wr(KBH_CMD_OFS, KBH_C_PWTST);
    ob("password loaded", KBH_R_PWYES, s);
    check("nothing to keyboard", 8'h00, 8'(kbd.got_q.size()));
    wr(KBH_CMD_OFS, KBH_C_PWEN);
    wr(KBH_CMD_OFS, KBH_C_AUXD);
    poll(KBH_ST_IBF, 1'b0, s);
    check("pw and aux off", 8'h03, {6'h00, password_enabled, aux_if_disabled});
    wr(KBH_CMD_OFS, KBH_C_AUXE);
    poll(KBH_ST_IBF, 1'b0, s);
    check("aux on", 8'h00, {7'h00, aux_if_disabled});
    wr(KBH_CMD_OFS, KBH_C_ECKB);
    wr(KBH_DATA_OFS, 8'h3c);
    ob("kbd echo", 8'h3c, s);
    check("echo kbd origin", 8'h00, {7'h00, s[KBH_ST_AUX]});
    wr(KBH_CMD_OFS, KBH_C_ECAUX);
    wr(KBH_DATA_OFS, 8'h5a);
    ob("aux echo", 8'h5a, s);
    check("echo aux origin", 8'h01, {7'h00, s[KBH_ST_AUX]});
    // low bits clear in data: only bit 1 may reach the port
    wr(KBH_CMD_OFS, KBH_C_WROUT);
    wr(KBH_DATA_OFS, 8'hfc);
    poll(KBH_ST_IBF, 1'b0, s);
    check("gate low", KBH_OUTP_RST & 8'hfd, output_port);
    wr(KBH_CMD_OFS, KBH_C_WROUT);
    wr(KBH_DATA_OFS, 8'h02);
    poll(KBH_ST_IBF, 1'b0, s);
    check("gate high", KBH_OUTP_RST, output_port);
    $display("test modes done");
  endtask
  task automatic t_fifo();
    logic [7:0] s;
    @(posedge core_clk);
    stall <= 1'b1;
    for (int i = 0; i < 9; i++) wr(KBH_DATA_OFS, 8'h80 + 8'(i));
    poll(KBH_ST_IBF, 1'b0, s);
    check("ibf while full", 8'h01, {7'h00, s[KBH_ST_IBF]});
    @(posedge core_clk);
    stall <= 1'b0;
    wr(KBH_CMD_OFS, KBH_C_TXAUX);
    wr(KBH_DATA_OFS, 8'h77);
    poll(KBH_ST_IBF, 1'b0, s);
    repeat (4) @(posedge core_clk);
    check("tx count", 8'd10, 8'(kbd.got_q.size()));
    for (int i = 0; i < 10 && i < kbd.got_q.size(); i++) begin
      check("tx byte", (i == 9) ? 8'h77 : 8'h80 + 8'(i), kbd.got_q[i][7:0]);
      check("tx aux", {7'h00, i == 9}, {7'h00, kbd.got_q[i][8]});
    end
    $display("test fifo done");
  endtask
  task automatic t_rx();
    logic [7:0] s;
    kbd.send(8'h9e, 1'b1, 1'b1, 1'b0);
    ob("rx aux byte", 8'h9e, s);
    check("aux tmo par", 8'h05, {5'h00, s[KBH_ST_AUX], s[KBH_ST_TMO], s[KBH_ST_PAR]});
    kbd.send(8'h61, 1'b0, 1'b0, 1'b1);
    ob("rx kbd byte", 8'h61, s);
    check("aux tmo par", 8'h02, {5'h00, s[KBH_ST_AUX], s[KBH_ST_TMO], s[KBH_ST_PAR]});
    @(posedge core_clk);
    kbd_inhibit_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(KBH_CMD_OFS, s);
    check("inhibit", 8'h00, {7'h00, s[KBH_ST_INH]});
    kbd_inhibit_n <= 1'b1;
    $display("test rx done");
  endtask
  task automatic t_pulse();
    int n;
    for (int c = 0; c < 16; c++) begin
      wr(KBH_CMD_OFS, 8'hf0 | 8'(c));
      n = 0;
      repeat (8) @(negedge core_clk);
      while (system_reset_line === 1'b0 && n < 200) begin
        @(negedge core_clk);
        n++;
      end
      // six low cycles pass before the eighth falling edge
      check("pulse cycles", c[0] ? 8'h00 : 8'(KBH_RST_CYC - 6), 8'(n));
    end
    $display("test pulse done");
  endtask
  task automatic t_nibble();
    logic [7:0] s;
    wr(KBH_CMD_OFS, KBH_C_INHI);
    poll(KBH_ST_IBF, 1'b0, s);
    check("high nibble", {4'h0, input_port[7:4]}, {4'h0, s[7:4]});
    wr(KBH_CMD_OFS, KBH_C_INLO);
    poll(KBH_ST_IBF, 1'b0, s);
    check("low nibble", {4'h0, input_port[3:0]}, {4'h0, s[7:4]});
    $display("test nibble done");
  endtask
  initial begin
    rst_n = 1'b0;
    {io_wr, io_rd, stall} = 3'h0;
    {io_addr, io_wdata} = 16'h0000;
    kbd_inhibit_n = 1'b1;
    input_port = 8'ha5;
    kbd_test_code = KBH_R_T_OK;
    aux_test_code = KBH_R_T_OK;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    t_basic();
    t_replies();
    t_modes();
    t_fifo();
    t_rx();
    t_pulse();
    t_nibble();
    stop_test();
  end
endmodule // keyboard_controller_host_port_test
bind kbh_host_port kbh_host_port_properties chk (.core_clk, .rst_n, .io_wr, .io_rd, .io_addr,
  .io_wdata, .io_rdata, .command_port_base, .tx_valid, .tx_ready, .tx_data, .tx_aux,
  .output_port, .address_line_20_gate, .system_reset_line, .aux_if_disabled,
  .password_enabled);
`default_nettype wire
